// >>> rtl/spisl_params.svh
// offsets, field positions, codes and reset values of the slave serial port
// assumes a 32-bit avalon-mm slave with a word index on the address port
`ifndef SPISL_PARAMS_SVH
`define SPISL_PARAMS_SVH

// word indices of the registers (byte address = 4 * index)
`define SPISL_IDX_CONTROL 3'h0
`define SPISL_IDX_BUFFER 3'h1
`define SPISL_IDX_STATUS 3'h2
`define SPISL_IDX_IRQ_STAT 3'h3
`define SPISL_IDX_IRQ_MASK 3'h4

// control register fields
`define SPISL_BIT_COLL 7
`define SPISL_BIT_OVF 6
`define SPISL_BIT_EN 5
`define SPISL_BIT_IDLE_POL 4
`define SPISL_CONTROL_RESET 8'h00

// mode select codes
`define SPISL_MODE_SLAVE_SS 4'h4
`define SPISL_MODE_SLAVE_NOSS 4'h5

// status and interrupt fields
`define SPISL_ST_FULL 0
`define SPISL_ST_BUSY 1
`define SPISL_ST_OWNED 2
`define SPISL_IRQ_BYTE 0
`define SPISL_IRQ_COLL 1
`define SPISL_IRQ_OVF 2
`define SPISL_IRQ_RESET 3'h0

`define SPISL_LAST_BIT 4'h7
`define SPISL_READ_UNMAPPED 32'h0000_0000

`endif

// >>> rtl/spisl_pkg.sv
// types of the slave serial port: bus request carrier and module state
// assumes spisl_params.svh for all numbers
package spisl_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [2:0] address;
    logic [31:0] writedata;
  } spisl_avmm_req_t;

  typedef struct packed {
    logic [2:0] sck_sync;
    logic [2:0] sdi_sync;
    logic [2:0] ssn_sync;
    logic sck_f;
    logic ssn_f;
    logic [7:0] control;
    logic [7:0] buffer;
    logic [7:0] shift;
    logic rx_bit;
    logic [3:0] bit_cnt;
    logic full;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
  } spisl_state_t;

endpackage : spisl_pkg

// >>> rtl/spisl_slave.sv
// slave-mode synchronous serial port with avalon-mm register access
// assumes clk_sys_in keeps running while the core sleeps; the serial
// clock, data-in and select pins are asynchronous and oversampled here
`timescale 1ns/100ps
`include "spisl_params.svh"

module spisl_slave (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // avalon-mm slave
  input wire spisl_pkg::spisl_avmm_req_t avmm_req_in,
  output logic [31:0] avmm_readdata_out,
  output logic avmm_waitrequest_out,
  // serial pins
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic ss_n_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic pins_owned_out,
  // core sleep and interrupt
  input wire logic core_sleep_in,
  output logic irq_out,
  output logic wake_out
);

  spisl_pkg::spisl_state_t s;
  spisl_pkg::spisl_state_t next_s;

  logic en;
  logic idle_pol;
  logic [3:0] mode;
  logic fsck;
  logic lead;
  logic trail;
  logic held;
  logic busy;
  logic take;
  logic take_wr;
  logic take_rd;
  logic byte_done;
  logic coll_ev;
  logic ovf_ev;
  logic [7:0] rx_byte;

  function automatic logic [31:0] read_mux(input spisl_pkg::spisl_state_t st,
                                           input logic [2:0] idx);
    logic [31:0] v;
    v = `SPISL_READ_UNMAPPED;
    unique case (idx)
      `SPISL_IDX_CONTROL: v[7:0] = st.control;
      `SPISL_IDX_BUFFER: v[7:0] = st.buffer;
      `SPISL_IDX_STATUS: begin
        v[`SPISL_ST_FULL] = st.full;
        v[`SPISL_ST_BUSY] = (st.bit_cnt != 4'h0);
        v[`SPISL_ST_OWNED] = st.control[`SPISL_BIT_EN];
      end
      `SPISL_IDX_IRQ_STAT: v[2:0] = st.irq_stat;
      `SPISL_IDX_IRQ_MASK: v[2:0] = st.irq_mask;
      default: v = `SPISL_READ_UNMAPPED;
    endcase
    return v;
  endfunction : read_mux

  assign en = s.control[`SPISL_BIT_EN];
  assign idle_pol = s.control[`SPISL_BIT_IDLE_POL];
  assign mode = s.control[3:0];
  // a pin change counts once the second and third stage agree
  assign fsck = (s.sck_sync[1] == s.sck_sync[2]) ? s.sck_sync[2] : s.sck_f;
  // leading edge leaves the idle level, trailing edge returns to it
  assign lead = (s.sck_f == idle_pol) && (fsck != idle_pol);
  assign trail = (s.sck_f != idle_pol) && (fsck == idle_pol);
  // master modes are not built; any other code parks the port
  assign held = !en || !((mode == `SPISL_MODE_SLAVE_NOSS) ||
                ((mode == `SPISL_MODE_SLAVE_SS) && !s.ssn_f));
  assign busy = (s.bit_cnt != 4'h0);
  // a request is taken at the edge that ends the cycle after its single wait cycle
  assign take = s.ack && (avmm_req_in.read || avmm_req_in.write);
  assign take_wr = take && avmm_req_in.write;
  assign take_rd = take && avmm_req_in.read;
  // sleep gates only wake_out: the shifter never looks at it
  assign byte_done = !held && trail && (s.bit_cnt == `SPISL_LAST_BIT);
  assign rx_byte = {s.shift[6:0], s.rx_bit};
  assign ovf_ev = byte_done && s.full;
  assign coll_ev = take_wr && (avmm_req_in.address == `SPISL_IDX_BUFFER) && busy;

  always_comb begin
    next_s = s;
    next_s.sck_sync = {s.sck_sync[1:0], sck_in};
    next_s.sdi_sync = {s.sdi_sync[1:0], sdi_in};
    next_s.ssn_sync = {s.ssn_sync[1:0], ss_n_in};
    next_s.sck_f = fsck;
    next_s.ssn_f = (s.ssn_sync[1] == s.ssn_sync[2]) ? s.ssn_sync[2] : s.ssn_f;

    // bus: one wait cycle, read data captured while waitrequest is high
    next_s.ack = (avmm_req_in.read || avmm_req_in.write) && !s.ack;
    if ((avmm_req_in.read || avmm_req_in.write) && !s.ack) begin
      next_s.rdata = read_mux(s, avmm_req_in.address);
    end

    // shifter: select high in select mode, a non-slave mode code or port disabled resets the bit counter
    if (held) begin
      next_s.bit_cnt = 4'h0;
    end else begin
      if (lead) begin
        next_s.rx_bit = s.sdi_sync[2];
      end
      if (trail) begin
        next_s.shift = rx_byte;
        next_s.bit_cnt = (s.bit_cnt == `SPISL_LAST_BIT) ? 4'h0 : s.bit_cnt + 4'h1;
      end
    end

    // software effects first so that hardware events win over clears
    if (take_wr) begin
      unique case (avmm_req_in.address)
        `SPISL_IDX_CONTROL: next_s.control = avmm_req_in.writedata[7:0];
        `SPISL_IDX_BUFFER: begin
          // ignored mid-byte; otherwise it preloads the next outgoing byte
          if (!busy) begin
            next_s.shift = avmm_req_in.writedata[7:0];
          end
        end
        `SPISL_IDX_IRQ_MASK: next_s.irq_mask = avmm_req_in.writedata[2:0];
        default: next_s.irq_mask = s.irq_mask;
      endcase
    end
    if (take_rd && (avmm_req_in.address == `SPISL_IDX_BUFFER)) begin
      next_s.full = 1'b0;
    end
    if (take_rd && (avmm_req_in.address == `SPISL_IDX_IRQ_STAT)) begin
      next_s.irq_stat = `SPISL_IRQ_RESET;
    end

    if (byte_done && !s.full) begin
      next_s.buffer = rx_byte;
      next_s.full = 1'b1;
    end
    if (byte_done) begin
      next_s.irq_stat[`SPISL_IRQ_BYTE] = 1'b1;
    end
    if (ovf_ev) begin
      next_s.control[`SPISL_BIT_OVF] = 1'b1;
      next_s.irq_stat[`SPISL_IRQ_OVF] = 1'b1;
    end
    if (coll_ev) begin
      next_s.control[`SPISL_BIT_COLL] = 1'b1;
      next_s.irq_stat[`SPISL_IRQ_COLL] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      s <= '0;
      s.control <= `SPISL_CONTROL_RESET;
      s.irq_stat <= `SPISL_IRQ_RESET;
      s.irq_mask <= `SPISL_IRQ_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign avmm_waitrequest_out = (avmm_req_in.read || avmm_req_in.write) && !s.ack;
  assign avmm_readdata_out = s.rdata;
  assign sdo_out = s.shift[7];
  assign sdo_oe_out = !held;
  assign pins_owned_out = en;
  assign irq_out = |(s.irq_stat & s.irq_mask);
  assign wake_out = core_sleep_in && s.irq_stat[`SPISL_IRQ_BYTE] &&
                    s.irq_mask[`SPISL_IRQ_BYTE];

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_sleep_shift: assert property (core_sleep_in && !held && trail |=>
    (s.shift == $past(rx_byte)) || $past(take_wr))
    else $error("shifter stalled during sleep");
  chk_shift_edge_only: assert property (!trail && !take_wr |=> $stable(s.shift))
    else $error("shift register moved without a serial clock edge");
  chk_byte_flag: assert property (byte_done |=> s.irq_stat[`SPISL_IRQ_BYTE])
    else $error("port interrupt flag not set after eighth bit");
  chk_stat_clear: assert property (take_rd && !byte_done
    && (avmm_req_in.address == `SPISL_IDX_IRQ_STAT) |=> s.irq_stat == `SPISL_IRQ_RESET)
    else $error("interrupt status not cleared by its read");
  chk_wake_core: assert property (core_sleep_in && s.irq_stat[0] && s.irq_mask[0]
    |-> wake_out && irq_out)
    else $error("enabled byte flag did not wake the core");
  // a trailing edge in the collision cycle may still move the shifter
  chk_coll_set: assert property (coll_ev |=> s.control[`SPISL_BIT_COLL]
    && ($stable(s.shift) || $past(trail)))
    else $error("collision not flagged or write not ignored");
  chk_coll_sticky: assert property (s.control[7] && !take_wr |=> s.control[7])
    else $error("collision flag cleared by hardware");
  chk_buffer_load: assert property (byte_done && !s.full |=> s.full
    && (s.buffer == $past(rx_byte)))
    else $error("received byte not moved to buffer");
  chk_full_clear: assert property (take_rd && !byte_done
    && (avmm_req_in.address == `SPISL_IDX_BUFFER) |=> !s.full)
    else $error("buffer read did not clear the full flag");
  chk_overflow_lost: assert property (ovf_ev |=> s.control[6] && $stable(s.buffer))
    else $error("overflow not flagged or buffer overwritten");
  chk_select_hold: assert property (en && (mode == `SPISL_MODE_SLAVE_SS) && s.ssn_f
    |-> !sdo_oe_out ##1 s.bit_cnt == 4'h0)
    else $error("select high did not hold the port in reset");
  chk_pins_release: assert property (!en |-> !pins_owned_out && !sdo_oe_out
    ##1 s.bit_cnt == 4'h0)
    else $error("disabled port still owns its pins");

endmodule : spisl_slave

// >>> testbench/spisl_master_model.sv
// behavioural spi master for the slave port: data set before the leading
// edge and sampled on it; the clock rests at a chosen idle level
// assumes the bench calls its tasks just after a rising edge of clk_sys_in
`timescale 1ns/100ps
module spisl_master_model (
  // clock
  input wire logic clk_sys_in,
  // serial pins
  input wire logic sdo_in,
  output logic sck_out,
  output logic sdi_out,
  output logic ss_n_out
);
  logic [7:0] rx;
  logic idle_lvl;
  initial begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    ss_n_out = 1'b1;
    idle_lvl = 1'b0;
  end
  // only while the port is disabled, or the move would count as an edge
  task automatic park(input logic lvl);
    idle_lvl = lvl;
    sck_out <= lvl;
    repeat (10) @(posedge clk_sys_in);
  endtask : park
  // 160 ns link period, clock stands still at idle between frames
  task automatic xfer(input logic [7:0] tx, input logic sel_n);
    ss_n_out <= sel_n;
    for (int i = 7; i >= 0; i--) begin
      sdi_out <= tx[i];
      repeat (10) @(posedge clk_sys_in);
      sck_out <= ~idle_lvl;
      rx[i] = sdo_in;
      repeat (10) @(posedge clk_sys_in);
      sck_out <= idle_lvl;
    end
    // released data line must not keep its last value
    sdi_out <= ~tx[0];
    repeat (10) @(posedge clk_sys_in);
    ss_n_out <= 1'b1;
    @(posedge clk_sys_in);
  endtask : xfer
endmodule : spisl_master_model

// >>> testbench/testbench.sv
// register-level tests of the slave port against a master model
// assumes word indices and field codes of spisl_params.svh
`timescale 1ns/100ps
`include "spisl_params.svh"
module testbench;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic core_sleep_in = 1'b0;
  spisl_pkg::spisl_avmm_req_t req = '0;
  logic [31:0] rdata;
  logic wreq, irq, wake, sdo, sdo_oe, owned, sck, sdi, ss_n;
  int fails = 0;
  int check_count = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  spisl_slave spisl_slave_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .avmm_req_in(req), .avmm_readdata_out(rdata), .avmm_waitrequest_out(wreq),
    .sck_in(sck), .sdi_in(sdi), .ss_n_in(ss_n), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .pins_owned_out(owned), .core_sleep_in(core_sleep_in), .irq_out(irq), .wake_out(wake));
  spisl_master_model spisl_master_model_i (.clk_sys_in(clk_sys_in), .sdo_in(sdo),
    .sck_out(sck), .sdi_out(sdi), .ss_n_out(ss_n));
  task automatic summarize();
    $display("compares %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    // only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk_sys_in);
    end while (wreq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h000000, d}, q);
  endtask : wr
  task automatic rd(input string nm, input logic [2:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(nm, {24'h000000, e}, q);
  endtask : rd
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd("control", `SPISL_IDX_CONTROL, `SPISL_CONTROL_RESET);
    rd("unmapped", 3'h7, 8'h00);
    chk("owned", 1'b0, owned);
    wr(`SPISL_IDX_CONTROL, 8'h25);
    chk("owned", 1'b1, owned);
    chk("sdo oe", 1'b1, sdo_oe);
    wr(`SPISL_IDX_IRQ_MASK, 8'h07);
    wr(`SPISL_IDX_BUFFER, 8'hA5);
    core_sleep_in <= 1'b1;
    // select high is ignored without select control
    spisl_master_model_i.xfer(8'h3C, 1'b1);
    chk("sdo byte", 8'hA5, spisl_master_model_i.rx);
    chk("wake", 1'b1, wake);
    rd("status", `SPISL_IDX_STATUS, 8'h05);
    wr(`SPISL_IDX_IRQ_MASK, 8'h00);
    chk("irq masked", 1'b0, irq);
    wr(`SPISL_IDX_IRQ_MASK, 8'h07);
    chk("irq", 1'b1, irq);
    rd("buffer", `SPISL_IDX_BUFFER, 8'h3C);
    rd("irq stat", `SPISL_IDX_IRQ_STAT, 8'h01);
    chk("irq cleared", 1'b0, irq);
    spisl_master_model_i.xfer(8'h11, 1'b0);
    spisl_master_model_i.xfer(8'h22, 1'b0);
    rd("control", `SPISL_IDX_CONTROL, 8'h65);
    rd("buffer", `SPISL_IDX_BUFFER, 8'h11);
    rd("irq stat", `SPISL_IDX_IRQ_STAT, 8'h05);
    wr(`SPISL_IDX_CONTROL, 8'h25);
    fork
      spisl_master_model_i.xfer(8'h55, 1'b0);
      begin
        repeat (40) @(posedge clk_sys_in);
        wr(`SPISL_IDX_BUFFER, 8'h99);
      end
    join
    rd("control", `SPISL_IDX_CONTROL, 8'hA5);
    rd("buffer", `SPISL_IDX_BUFFER, 8'h55);
    rd("irq stat", `SPISL_IDX_IRQ_STAT, 8'h03);
    wr(`SPISL_IDX_CONTROL, 8'h24);
    rd("control", `SPISL_IDX_CONTROL, 8'h24);
    spisl_master_model_i.xfer(8'h77, 1'b1);
    rd("status", `SPISL_IDX_STATUS, 8'h04);
    chk("sdo oe", 1'b0, sdo_oe);
    spisl_master_model_i.xfer(8'h66, 1'b0);
    rd("buffer", `SPISL_IDX_BUFFER, 8'h66);
    // idle-high clock: move the pin only while the port is disabled
    wr(`SPISL_IDX_CONTROL, 8'h14);
    spisl_master_model_i.park(1'b1);
    wr(`SPISL_IDX_CONTROL, 8'h35);
    wr(`SPISL_IDX_BUFFER, 8'hC3);
    spisl_master_model_i.xfer(8'h5A, 1'b0);
    chk("sdo byte", 8'hC3, spisl_master_model_i.rx);
    rd("buffer", `SPISL_IDX_BUFFER, 8'h5A);
    core_sleep_in <= 1'b0;
    @(posedge clk_sys_in);
    chk("wake", 1'b0, wake);
    chk("irq", 1'b1, irq);
    wr(`SPISL_IDX_CONTROL, 8'h04);
    chk("owned", 1'b0, owned);
    summarize();
  end
endmodule : testbench
